/* logic/relps_pkg.sv */
// constants shared by the rom, eeprom and led pin sharing block
package relps_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned CLK_FREQ_KHZ   = 100000;
  localparam int unsigned EE_SCK_KHZ     = 150;
  // half period of the serial prom clock, rounded down
  localparam logic [8:0]  EE_HALF_CYC    = 9'(CLK_FREQ_KHZ / (2 * EE_SCK_KHZ));
  localparam int unsigned ROM_ACCESS_NS  = 120;
  // strobe width, rounded up to whole cycles
  localparam logic [8:0]  ROM_STROBE_CYC = 9'((ROM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned CNT_W          = 9;

  // layout of the synchroniser vector
  localparam int unsigned SYNC_W   = 15;
  localparam int unsigned S_GIG    = 0;
  localparam int unsigned S_FAST   = 1;
  localparam int unsigned S_TEN    = 2;
  localparam int unsigned S_DPLX   = 3;
  localparam int unsigned S_DATA   = 4;
  localparam int unsigned S_A7     = 12;
  localparam int unsigned S_A6     = 13;
  localparam int unsigned S_A5     = 14;

  // reset values
  localparam logic [SYNC_W-1:0] SYNC_RST = 15'h0007;
  localparam logic              PIN_HIGH = 1'b1;
  localparam logic              PIN_LOW  = 1'b0;

  typedef enum logic [3:0] {
    RELPS_IDLE   = 4'b0001,
    RELPS_SETUP  = 4'b0010,
    RELPS_STROBE = 4'b0100,
    RELPS_HOLD   = 4'b1000
  } relps_rom_state_t;
endpackage : relps_pkg

/* logic/relps_pin_share.sv */
// shared expansion rom, serial prom, gpio and status led pins
// Behaviour
// - gigabit link input low means gigabit link up.
// - fast link input low means 100 Mb/s link up.
// - ten link input low means 10 Mb/s link up.
// - duplex input polarity programmable; asserted is full duplex, deasserted half.
// - duplex input ignored while ten link input is not asserted.
// - serial prom select asserted for the whole prom access only.
// - eight-bit rom data bus driven on writes, sampled on reads.
// - pin carries rom address bit 15 in access, else ten link led.
// - pin carries rom address bit 14 in access, else fast link led.
// - dedicated outputs carry rom address bits 13 to 8.
// - address bits 7 and 6 in access, else general io bits 1 and 0.
// - address bit 5 in access, else input from serial prom data out.
// - address bit 4 in access, else serial prom clock near 150 kHz.
// - address bit 3 in access, else serial data into the prom.
// - address bits 2..0 in access, else power, gigabit and duplex leds.
`timescale 1ns/100ps
module relps_pin_share (
  input  wire logic       clk,
  input  wire logic       rstn,
  // core side: rom access
  input  wire logic       rom_start,
  input  wire logic       rom_write,
  input  wire logic [15:0] rom_addr,
  input  wire logic [7:0] rom_wdata,
  output logic            rom_busy,
  output logic            rom_done,
  output logic [7:0]      rom_rdata,
  // core side: serial prom
  input  wire logic       prom_access,
  input  wire logic       prom_tx_bit,
  output logic            prom_rx_bit,
  output logic            prom_bit_strobe,
  // core side: gpio, power and status
  input  wire logic [1:0] gio_out,
  input  wire logic [1:0] gio_drive,
  output logic [1:0]      gio_in,
  input  wire logic       power_on,
  input  wire logic       duplex_active_high,
  output logic            gig_link_up,
  output logic            fast_link_up,
  output logic            ten_link_up,
  output logic            full_duplex,
  // phy status pins
  input  wire logic       phy_gig_link_up_n,
  input  wire logic       phy_fast_link_up_n,
  input  wire logic       phy_ten_link_up_n,
  input  wire logic       phy_full_duplex_status,
  // rom, prom and led pins
  output logic            serial_prom_select,
  input  wire logic [7:0] boot_rom_data_bus_in,
  output logic [7:0]      boot_rom_data_bus_out,
  output logic            boot_rom_data_bus_oe_n,
  output logic            rom_write_en_n,
  output logic            rom_output_en_n,
  output logic [13:8]     boot_rom_address_bus,
  output logic            a15_ten_link_led_n,
  output logic            a14_fast_link_led_n,
  input  wire logic       a7_general_io_bit1_in,
  output logic            a7_general_io_bit1_out,
  output logic            a7_general_io_bit1_oe_n,
  input  wire logic       a6_general_io_bit0_in,
  output logic            a6_general_io_bit0_out,
  output logic            a6_general_io_bit0_oe_n,
  input  wire logic       a5_serial_prom_data_out_in,
  output logic            a5_serial_prom_data_out_out,
  output logic            a5_serial_prom_data_out_oe_n,
  output logic            a4_serial_prom_clock,
  output logic            a3_serial_prom_data_in,
  output logic            a2_power_led_n,
  output logic            a1_gig_link_led_n,
  output logic            a0_duplex_led_n
);
  // led pins are lit by pulling low
  function automatic logic led_drive(input logic lit);
    led_drive = ~lit;
  endfunction : led_drive
  logic [relps_pkg::SYNC_W-1:0] sync_meta_reg;
  logic [relps_pkg::SYNC_W-1:0] sync_reg;
  relps_pkg::relps_rom_state_t  state_reg;
  relps_pkg::relps_rom_state_t  state_next;
  logic [relps_pkg::CNT_W-1:0]  rom_cnt_reg;
  logic [15:0]                  boot_rom_addr_reg;
  logic [7:0]                   boot_rom_data_reg;
  logic                         write_reg;
  logic [relps_pkg::CNT_W-1:0]  sck_cnt_reg;
  logic                         sck_reg;
  logic                         in_access;
  logic                         gig_up;
  logic                         fast_up;
  logic                         ten_up;
  logic                         dplx_full;
  logic                         prom_run;
  logic                         rom_take;
  logic [15:0]                  addr_cur;
  // every pin input passes two flops before use
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync_meta_reg <= relps_pkg::SYNC_RST;
      sync_reg      <= relps_pkg::SYNC_RST;
    end else begin
      sync_meta_reg <= {a5_serial_prom_data_out_in, a6_general_io_bit0_in,
                        a7_general_io_bit1_in, boot_rom_data_bus_in,
                        phy_full_duplex_status, phy_ten_link_up_n,
                        phy_fast_link_up_n, phy_gig_link_up_n};
      sync_reg      <= sync_meta_reg;
    end
  end
  assign gig_up    = ~sync_reg[relps_pkg::S_GIG];
  assign fast_up   = ~sync_reg[relps_pkg::S_FAST];
  assign ten_up    = ~sync_reg[relps_pkg::S_TEN];
  // duplex level is undefined without a ten link, so it is masked
  assign dplx_full = ten_up &&
                     (sync_reg[relps_pkg::S_DPLX] == duplex_active_high);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gig_link_up  <= 1'b0;
      fast_link_up <= 1'b0;
      ten_link_up  <= 1'b0;
      full_duplex  <= 1'b0;
      gio_in       <= 2'h0;
    end else begin
      gig_link_up  <= gig_up;
      fast_link_up <= fast_up;
      ten_link_up  <= ten_up;
      full_duplex  <= dplx_full;
      gio_in       <= {sync_reg[relps_pkg::S_A7], sync_reg[relps_pkg::S_A6]};
    end
  end
  // rom access sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      relps_pkg::RELPS_IDLE: begin
        if (rom_start) begin
          state_next = relps_pkg::RELPS_SETUP;
        end
      end
      relps_pkg::RELPS_SETUP:  state_next = relps_pkg::RELPS_STROBE;
      relps_pkg::RELPS_STROBE: begin
        if (rom_cnt_reg == relps_pkg::ROM_STROBE_CYC - 9'h001) begin
          state_next = relps_pkg::RELPS_HOLD;
        end
      end
      relps_pkg::RELPS_HOLD:   state_next = relps_pkg::RELPS_IDLE;
      default:                 state_next = relps_pkg::RELPS_IDLE;
    endcase
  end
  assign in_access = (state_next != relps_pkg::RELPS_IDLE);
  // pins switch at the taking edge, before the request copies exist
  assign rom_take  = (state_reg == relps_pkg::RELPS_IDLE) && rom_start;
  assign addr_cur  = rom_take ? rom_addr : boot_rom_addr_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= relps_pkg::RELPS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rom_cnt_reg <= 9'h000;
    end else if (state_reg == relps_pkg::RELPS_STROBE) begin
      rom_cnt_reg <= rom_cnt_reg + 9'h001;
    end else begin
      rom_cnt_reg <= 9'h000;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      boot_rom_addr_reg <= 16'h0000;
      boot_rom_data_reg <= 8'h00;
      write_reg         <= 1'b0;
    end else if (state_reg == relps_pkg::RELPS_IDLE && rom_start) begin
      boot_rom_addr_reg <= rom_addr;
      boot_rom_data_reg <= rom_wdata;
      write_reg         <= rom_write;
    end
  end
  // read data sampled at the close of the strobe, bus long settled by then
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rom_rdata <= 8'h00;
      rom_done  <= 1'b0;
      rom_busy  <= 1'b0;
    end else begin
      if (state_next == relps_pkg::RELPS_HOLD && !write_reg) begin
        rom_rdata <= sync_reg[relps_pkg::S_DATA +: 8];
      end
      rom_done <= (state_next == relps_pkg::RELPS_HOLD);
      rom_busy <= in_access;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      boot_rom_data_bus_out  <= 8'h00;
      boot_rom_data_bus_oe_n <= relps_pkg::PIN_HIGH;
      rom_write_en_n         <= relps_pkg::PIN_HIGH;
      rom_output_en_n        <= relps_pkg::PIN_HIGH;
    end else begin
      boot_rom_data_bus_out  <= rom_take ? rom_wdata : boot_rom_data_reg;
      boot_rom_data_bus_oe_n <= ~(in_access && (rom_take ? rom_write : write_reg));
      rom_write_en_n  <= ~(state_next == relps_pkg::RELPS_STROBE && write_reg);
      rom_output_en_n <= ~(state_next == relps_pkg::RELPS_STROBE && !write_reg);
    end
  end

  // serial prom clock pauses while the rom owns the pins
  assign prom_run = prom_access && !in_access;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sck_cnt_reg     <= 9'h000;
      sck_reg         <= 1'b0;
      prom_rx_bit     <= 1'b0;
      prom_bit_strobe <= 1'b0;
    end else begin
      prom_bit_strobe <= 1'b0;
      if (!prom_access) begin
        sck_cnt_reg <= 9'h000;
        sck_reg     <= 1'b0;
      end else if (prom_run) begin
        if (sck_cnt_reg == relps_pkg::EE_HALF_CYC - 9'h001) begin
          sck_cnt_reg <= 9'h000;
          sck_reg     <= ~sck_reg;
          if (!sck_reg) begin
            prom_rx_bit     <= sync_reg[relps_pkg::S_A5];
            prom_bit_strobe <= 1'b1;
          end
        end else begin
          sck_cnt_reg <= sck_cnt_reg + 9'h001;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      serial_prom_select <= 1'b0;
    end else begin
      serial_prom_select <= prom_access;
    end
  end

  // shared pins: rom address first, alternate function otherwise
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      boot_rom_address_bus         <= 6'h00;
      a15_ten_link_led_n           <= relps_pkg::PIN_HIGH;
      a14_fast_link_led_n          <= relps_pkg::PIN_HIGH;
      a7_general_io_bit1_out       <= relps_pkg::PIN_LOW;
      a7_general_io_bit1_oe_n      <= relps_pkg::PIN_HIGH;
      a6_general_io_bit0_out       <= relps_pkg::PIN_LOW;
      a6_general_io_bit0_oe_n      <= relps_pkg::PIN_HIGH;
      a5_serial_prom_data_out_out  <= relps_pkg::PIN_LOW;
      a5_serial_prom_data_out_oe_n <= relps_pkg::PIN_HIGH;
      a4_serial_prom_clock         <= relps_pkg::PIN_LOW;
      a3_serial_prom_data_in       <= relps_pkg::PIN_LOW;
      a2_power_led_n               <= relps_pkg::PIN_HIGH;
      a1_gig_link_led_n            <= relps_pkg::PIN_HIGH;
      a0_duplex_led_n              <= relps_pkg::PIN_HIGH;
    end else if (in_access) begin
      boot_rom_address_bus         <= addr_cur[13:8];
      a15_ten_link_led_n           <= addr_cur[15];
      a14_fast_link_led_n          <= addr_cur[14];
      a7_general_io_bit1_out       <= addr_cur[7];
      a7_general_io_bit1_oe_n      <= relps_pkg::PIN_LOW;
      a6_general_io_bit0_out       <= addr_cur[6];
      a6_general_io_bit0_oe_n      <= relps_pkg::PIN_LOW;
      a5_serial_prom_data_out_out  <= addr_cur[5];
      a5_serial_prom_data_out_oe_n <= relps_pkg::PIN_LOW;
      a4_serial_prom_clock         <= addr_cur[4];
      a3_serial_prom_data_in       <= addr_cur[3];
      a2_power_led_n               <= addr_cur[2];
      a1_gig_link_led_n            <= addr_cur[1];
      a0_duplex_led_n              <= addr_cur[0];
    end else begin
      a15_ten_link_led_n           <= led_drive(ten_up);
      a14_fast_link_led_n          <= led_drive(fast_up);
      a7_general_io_bit1_out       <= gio_out[1];
      a7_general_io_bit1_oe_n      <= ~gio_drive[1];
      a6_general_io_bit0_out       <= gio_out[0];
      a6_general_io_bit0_oe_n      <= ~gio_drive[0];
      a5_serial_prom_data_out_out  <= relps_pkg::PIN_LOW;
      a5_serial_prom_data_out_oe_n <= relps_pkg::PIN_HIGH;
      a4_serial_prom_clock         <= sck_reg;
      a3_serial_prom_data_in       <= prom_tx_bit;
      a2_power_led_n               <= led_drive(power_on);
      a1_gig_link_led_n            <= led_drive(gig_up);
      a0_duplex_led_n              <= led_drive(dplx_full);
    end
  end

endmodule : relps_pin_share

/* verification/relps_pin_share_assertions.sv */
// assertion checker for the shared rom, prom and led pins
`timescale 1ns/100ps
module relps_pin_share_chk (
  input wire logic        clk, rstn, rom_start, rom_write, rom_busy, rom_done, prom_access,
  input wire logic [15:0] rom_addr,
  input wire logic [7:0]  rom_wdata, boot_rom_data_bus_out,
  input wire logic        gig_link_up, fast_link_up, ten_link_up, full_duplex,
  input wire logic        phy_gig_link_up_n, phy_fast_link_up_n, phy_ten_link_up_n,
  input wire logic        serial_prom_select, boot_rom_data_bus_oe_n,
  input wire logic [13:8] boot_rom_address_bus,
  input wire logic        a15_ten_link_led_n, a14_fast_link_led_n, a4_serial_prom_clock,
  input wire logic        a7_general_io_bit1_out, a7_general_io_bit1_oe_n,
  input wire logic        a6_general_io_bit0_out, a6_general_io_bit0_oe_n,
  input wire logic        a5_serial_prom_data_out_out, a5_serial_prom_data_out_oe_n,
  input wire logic        a3_serial_prom_data_in, a2_power_led_n, a1_gig_link_led_n,
  input wire logic        a0_duplex_led_n
);
  wire logic [15:0] pins = {a15_ten_link_led_n, a14_fast_link_led_n, boot_rom_address_bus,
    a7_general_io_bit1_out, a6_general_io_bit0_out, a5_serial_prom_data_out_out,
    a4_serial_prom_clock, a3_serial_prom_data_in, a2_power_led_n, a1_gig_link_led_n,
    a0_duplex_led_n};
  wire logic        drv_n = a7_general_io_bit1_oe_n | a6_general_io_bit0_oe_n
                            | a5_serial_prom_data_out_oe_n;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_gig_link: assert property ((!phy_gig_link_up_n)[*4] |=> gig_link_up)
    else $error("gig link not decoded");
  a_fast_link: assert property (phy_fast_link_up_n[*4] |=> !fast_link_up)
    else $error("fast link not decoded");
  a_ten_link: assert property ((!phy_ten_link_up_n)[*4] |=> ten_link_up)
    else $error("ten link not decoded");
  a_duplex_gate: assert property (phy_ten_link_up_n[*4] |=> !full_duplex)
    else $error("duplex shown without ten link");
  a_prom_select: assert property (1'b1 |=> serial_prom_select == $past(prom_access))
    else $error("prom select does not follow access");
  a_done_time: assert property (rom_start && !rom_busy |-> ##14 rom_done)
    else $error("rom access length wrong");
  a_rom_pins: assert property ($rose(rom_busy) |-> pins == $past(rom_addr) && !drv_n)
    else $error("shared pins miss rom address");
  a_write_drive: assert property ($rose(rom_busy) && $past(rom_write) |->
    !boot_rom_data_bus_oe_n && boot_rom_data_bus_out == $past(rom_wdata))
    else $error("write data not driven");
  a_bus_release: assert property (!rom_busy |-> boot_rom_data_bus_oe_n)
    else $error("data bus driven while idle");
  a_led_restore: assert property (!rom_busy |-> {pins[15:14], pins[1:0]} ==
    ~{ten_link_up, fast_link_up, gig_link_up, full_duplex})
    else $error("led pins disagree with status");
  a_clock_idle: assert property ((!prom_access && !rom_busy)[*3] |-> !a4_serial_prom_clock)
    else $error("prom clock runs without access");
endmodule : relps_pin_share_chk

bind relps_pin_share relps_pin_share_chk i_chk (.clk, .rstn, .rom_start, .rom_write,
  .rom_busy, .rom_done, .prom_access, .rom_addr, .rom_wdata, .boot_rom_data_bus_out,
  .gig_link_up, .fast_link_up, .ten_link_up, .full_duplex, .phy_gig_link_up_n,
  .phy_fast_link_up_n, .phy_ten_link_up_n, .serial_prom_select, .boot_rom_data_bus_oe_n,
  .boot_rom_address_bus, .a15_ten_link_led_n, .a14_fast_link_led_n, .a4_serial_prom_clock,
  .a7_general_io_bit1_out, .a7_general_io_bit1_oe_n, .a6_general_io_bit0_out,
  .a6_general_io_bit0_oe_n, .a5_serial_prom_data_out_out, .a5_serial_prom_data_out_oe_n,
  .a3_serial_prom_data_in, .a2_power_led_n, .a1_gig_link_led_n, .a0_duplex_led_n);

/* verification/relps_far_side.sv */
// far side model: expansion rom and serial prom on the shared pins
`timescale 1ns/100ps
module relps_far_side (
  input  wire logic        rom_output_en_n, rom_write_en_n, boot_rom_data_bus_oe_n,
  input  wire logic [15:0] pin_addr,
  input  wire logic [7:0]  boot_rom_data_bus_out,
  input  wire logic        serial_prom_select, a4_serial_prom_clock,
  input  wire logic        a5_serial_prom_data_out_out, a5_serial_prom_data_out_oe_n,
  output logic [7:0]       boot_rom_data_bus_in,
  output logic             a5_serial_prom_data_out_in
);
  logic [7:0] mem [256];
  logic [7:0] last_rd = 8'h00;
  logic       ee_bit  = 1'b0;
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
  end
  // rom takes the byte as its write strobe closes
  always @(posedge rom_write_en_n) mem[pin_addr[7:0]] = boot_rom_data_bus_out;
  always @(negedge rom_output_en_n) last_rd = mem[pin_addr[7:0]];
  // released bus shows the inverse of the last byte while the rom output enable is off, else the byte itself
  assign boot_rom_data_bus_in = !boot_rom_data_bus_oe_n ? boot_rom_data_bus_out
                              : (rom_output_en_n ? ~last_rd : last_rd);
  // prom shifts a new bit out on each falling serial clock
  always @(negedge a4_serial_prom_clock) if (serial_prom_select) ee_bit = ~ee_bit;
  assign a5_serial_prom_data_out_in = !a5_serial_prom_data_out_oe_n
    ? a5_serial_prom_data_out_out : (serial_prom_select ? ee_bit : ~ee_bit);
endmodule : relps_far_side

/* verification/test_rom_eeprom_led_pin_share.sv */
// self-checking bench for the rom, serial prom and led pin sharing block
`timescale 1ns/100ps
module test_rom_eeprom_led_pin_share;
  logic clk = 1'b0, rstn = 1'b0, rom_start = 1'b0, rom_write = 1'b0, power_on = 1'b0;
  logic prom_access = 1'b0, prom_tx_bit = 1'b0, duplex_active_high = 1'b0;
  logic phy_gig_link_up_n = 1'b1, phy_fast_link_up_n = 1'b1, phy_ten_link_up_n = 1'b1;
  logic phy_full_duplex_status = 1'b0;
  logic [15:0] rom_addr = 16'h0000;
  logic [7:0] rom_wdata = 8'h00, rom_rdata, boot_rom_data_bus_in, boot_rom_data_bus_out;
  logic [1:0] gio_out = 2'b00, gio_drive = 2'b00, gio_ext = 2'b10, gio_in;
  logic rom_busy, rom_done, prom_rx_bit, prom_bit_strobe, gig_link_up, fast_link_up;
  logic ten_link_up, full_duplex, serial_prom_select, boot_rom_data_bus_oe_n;
  logic rom_write_en_n, rom_output_en_n, a15_ten_link_led_n, a14_fast_link_led_n;
  logic [13:8] boot_rom_address_bus;
  logic a7_general_io_bit1_in, a7_general_io_bit1_out, a7_general_io_bit1_oe_n;
  logic a6_general_io_bit0_in, a6_general_io_bit0_out, a6_general_io_bit0_oe_n;
  logic a5_serial_prom_data_out_in, a5_serial_prom_data_out_out, a5_serial_prom_data_out_oe_n;
  logic a4_serial_prom_clock, a3_serial_prom_data_in, a2_power_led_n, a1_gig_link_led_n;
  logic a0_duplex_led_n;
  int n_errors = 0, checked = 0;
  wire logic [15:0] pin_addr = {a15_ten_link_led_n, a14_fast_link_led_n, boot_rom_address_bus,
    a7_general_io_bit1_out, a6_general_io_bit0_out, a5_serial_prom_data_out_out,
    a4_serial_prom_clock, a3_serial_prom_data_in, a2_power_led_n, a1_gig_link_led_n,
    a0_duplex_led_n};
  // gpio pin level: the block wins while it drives, else the outside level
  assign a7_general_io_bit1_in = a7_general_io_bit1_oe_n ? gio_ext[1] : a7_general_io_bit1_out;
  assign a6_general_io_bit0_in = a6_general_io_bit0_oe_n ? gio_ext[0] : a6_general_io_bit0_out;
  always #5 clk = ~clk;
  relps_pin_share i_dut (.clk, .rstn, .rom_start, .rom_write, .rom_addr, .rom_wdata,
    .rom_busy, .rom_done, .rom_rdata, .prom_access, .prom_tx_bit, .prom_rx_bit,
    .prom_bit_strobe, .gio_out, .gio_drive, .gio_in, .power_on, .duplex_active_high,
    .gig_link_up, .fast_link_up, .ten_link_up, .full_duplex, .phy_gig_link_up_n,
    .phy_fast_link_up_n, .phy_ten_link_up_n, .phy_full_duplex_status, .serial_prom_select,
    .boot_rom_data_bus_in, .boot_rom_data_bus_out, .boot_rom_data_bus_oe_n, .rom_write_en_n,
    .rom_output_en_n, .boot_rom_address_bus, .a15_ten_link_led_n, .a14_fast_link_led_n,
    .a7_general_io_bit1_in, .a7_general_io_bit1_out, .a7_general_io_bit1_oe_n,
    .a6_general_io_bit0_in, .a6_general_io_bit0_out, .a6_general_io_bit0_oe_n,
    .a5_serial_prom_data_out_in, .a5_serial_prom_data_out_out, .a5_serial_prom_data_out_oe_n,
    .a4_serial_prom_clock, .a3_serial_prom_data_in, .a2_power_led_n, .a1_gig_link_led_n,
    .a0_duplex_led_n);
  relps_far_side i_far (.rom_output_en_n, .rom_write_en_n, .boot_rom_data_bus_oe_n, .pin_addr,
    .boot_rom_data_bus_out, .serial_prom_select, .a4_serial_prom_clock,
    .a5_serial_prom_data_out_out, .a5_serial_prom_data_out_oe_n, .boot_rom_data_bus_in,
    .a5_serial_prom_data_out_in);
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask : check
  task finish_test;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  task automatic wait_hi(ref logic sig, input int lim, output int k);
    for (k = 1; k <= lim; k++) begin
      @(negedge clk);
      if (sig === 1'b1) break;
    end
    if (k > lim) begin
      n_errors++;
      finish_test();
    end
  endtask : wait_hi
  task automatic rom_op(input logic wr, input logic [15:0] a, input logic [7:0] d);
    int k;
    {rom_start, rom_write, rom_addr, rom_wdata} = {1'b1, wr, a, d};
    @(negedge clk);
    rom_start = 1'b0;
    rom_addr = ~a; // must be ignored once the access is taken
    repeat (2) @(negedge clk);
    check(pin_addr, a);
    check(rom_busy, 1'b1);
    wait_hi(rom_done, 20, k);
    @(negedge clk);
    check(rom_busy, 1'b0);
    check(a15_ten_link_led_n, phy_ten_link_up_n);
    if (!wr) check(rom_rdata, d);
  endtask : rom_op
  task automatic t_status;
    logic [4:0] tab [5] = '{5'b01101, 5'b10011, 5'b11000, 5'b11001, 5'b00111};
    logic       f;
    foreach (tab[i]) begin
      {phy_gig_link_up_n, phy_fast_link_up_n, phy_ten_link_up_n, phy_full_duplex_status,
       duplex_active_high} = tab[i];
      power_on = tab[i][0];
      f = !tab[i][2] && (tab[i][1] == tab[i][0]);
      repeat (6) @(negedge clk);
      check({gig_link_up, fast_link_up, ten_link_up}, {~tab[i][4:2]});
      check(full_duplex, f);
      check({a15_ten_link_led_n, a14_fast_link_led_n, a1_gig_link_led_n, a0_duplex_led_n,
             a2_power_led_n}, {tab[i][2], tab[i][3], tab[i][4], !f, !tab[i][0]});
    end
  endtask : t_status
  task t_rom;
    rom_op(1'b1, 16'hc3a5, 8'h3c);
    rom_op(1'b0, 16'hc3a5, 8'h3c);
    rom_op(1'b0, 16'h5a12, 8'h48); // untouched cell keeps its preset pattern
  endtask : t_rom
  task automatic t_prom;
    int k;
    {prom_tx_bit, prom_access} = 2'b11;
    repeat (3) @(negedge clk);
    check(serial_prom_select, 1'b1);
    check(a3_serial_prom_data_in, 1'b1);
    for (int b = 0; b < 3; b++) begin
      wait_hi(prom_bit_strobe, 800, k);
      check(prom_rx_bit, b[0]);
      if (b > 0) check(16'(k), 16'h029a);
    end
    {prom_tx_bit, prom_access} = 2'b00;
    repeat (3) @(negedge clk);
    check({serial_prom_select, a4_serial_prom_clock, a3_serial_prom_data_in}, 3'h0);
  endtask : t_prom
  task t_gpio;
    {gio_drive, gio_out} = 4'hd;
    repeat (6) @(negedge clk);
    check({a7_general_io_bit1_out, a6_general_io_bit0_out, a7_general_io_bit1_oe_n,
           a6_general_io_bit0_oe_n, gio_in}, 6'h11);
    gio_drive = 2'b00;
    repeat (6) @(negedge clk);
    check({a7_general_io_bit1_oe_n, a6_general_io_bit0_oe_n, gio_in}, 4'he);
  endtask : t_gpio
  initial begin
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    t_status();
    t_rom();
    t_prom();
    t_gpio();
    finish_test();
  end
endmodule : test_rom_eeprom_led_pin_share
